/* shc_pkg.sv */
`default_nettype none
package shc_pkg;
  // bus and queue geometry
  localparam int AW = 6;
  localparam int DW = 32;
  localparam int QW = 16;
  localparam int QD = 8;
  localparam int QPW = 4;
  // register byte offsets
  localparam logic [AW-1:0] OFF_CTRL = 6'h00;
  localparam logic [AW-1:0] OFF_TRANSMIT_DATA_PORT = 6'h04;
  localparam logic [AW-1:0] OFF_RECEIVE_DATA_PORT = 6'h08;
  localparam logic [AW-1:0] OFF_TRANSMIT_CHECKSUM_STATE = 6'h0c;
  localparam logic [AW-1:0] OFF_RECEIVE_CHECKSUM_STATE = 6'h10;
  localparam logic [AW-1:0] OFF_HDR1 = 6'h14;
  localparam logic [AW-1:0] OFF_HDR2 = 6'h18;
  localparam logic [AW-1:0] OFF_HDR3 = 6'h1c;
  localparam logic [AW-1:0] OFF_HDR4 = 6'h20;
  localparam logic [AW-1:0] OFF_HDRC = 6'h24;
  localparam logic [AW-1:0] OFF_STATUS = 6'h28;
  // control_register_zero fields
  localparam int CTL_EN = 0;
  localparam int CTL_CTRLR = 1;
  localparam int CTL_POLY16 = 2;
  localparam int CTL_GPCRC = 3;
  localparam int CTL_DSS_LO = 8;
  localparam int CTL_DSS_HI = 11;
  localparam int CTL_AUTO = 14;
  localparam int CTL_IDLE = 17;
  localparam logic [DW-1:0] CTRL_RST = 32'h0000_0700;
  // header_preload_control fields
  localparam int HC_EN = 0;
  localparam int HC_CMT = 1;
  localparam int HC_IGN = 2;
  localparam int HC_GATE = 3;
  // checksum constants
  localparam int TRANSMIT_CHECKSUM_STATE_RESEED_BIT = 31;
  localparam logic [QW-1:0] SEED8 = 16'h00ff;
  localparam logic [QW-1:0] SEED16 = 16'hffff;
  localparam logic [QW-1:0] POLY8 = 16'h0007;
  localparam logic [QW-1:0] POLY16 = 16'h1021;
  localparam logic [3:0] DSS16 = 4'hf;
  // control word length, last bit index
  localparam logic [3:0] CW_LAST = 4'h7;
  // link timing: clock rate and serial bit period
  localparam int CLK_HZ = 10_000_000;
  localparam int SCLK_PERIOD_NS = 800;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] HALF_M1 = 4'(HALF_CYC - 1);
  // sync bit positions
  localparam int SY_SCLK = 0;
  localparam int SY_CS = 1;
  localparam int SY_PICO = 2;
  localparam int SY_POCI = 3;
  localparam logic [3:0] SYNC_RST = 4'h2;
  // controller frame states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CTRL = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_RESP = 5'b01000,
    ST_TAIL = 5'b10000
  } shc_state_t;
endpackage
`default_nettype wire

/* shc_top.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - control byte first, no capture meanwhile
// - response 1 to 16 bits long
// - idle: clock low, select high, data low
// - queued byte starts frame, MSB out first
// - far end waits one clock; we sample rising
// - select rises one period after last bit
// - continuous: next control right after LSB
// - always-on transmit and receive engines, CRC8 or CRC16 by bit 2
// - seeds 0xFF or 0xFFFF
// - data write/read also steps checksum
// - checksum read back leaves zero residue
// - stand-alone transmit checksum when port off
// - underflow auto-inserts computed checksum
// - checksum register reads reseed engines
// - auto insert only 8-bit, controller role
// - header write: reset, reseed, push bytes
// - hold requests until header committed
// - late header write sets ignored flag
// - select gate and header enable handling
// - peripheral idle output level from bit 17
module shc_top (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire logic [shc_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [shc_pkg::DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [shc_pkg::DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // serial link pins
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic cs_n_i,
  output logic cs_n_o,
  output logic cs_n_oe,
  input wire logic pico_i,
  output logic pico_o,
  output logic pico_oe,
  input wire logic poci_i,
  output logic poci_o,
  output logic poci_oe,
  // request hold towards dma and interrupts
  output logic req_hold
);
  import shc_pkg::*;

  // registers
  logic [DW-1:0] ctrl_ff;
  logic hdr_en_ff, hdr_cmt_ff, hdr_ign_ff, gate_ff, hdr_pend_ff;
  logic [2:0] hdr_left_ff;
  logic [DW-1:0] hdr_word_ff;
  logic [QW-1:0] transmit_checksum_state_ff, receive_checksum_state_ff;
  logic crc_ins_ff, sent_ff;
  // queues and pointers
  logic [QW-1:0] txq [QD];
  logic [QW-1:0] rxq [QD];
  logic [QPW-1:0] txw_ff, txr_ff, rxw_ff, rxr_ff;
  // bus handshake
  logic ack_ff, rxnz_ff;
  logic [DW-1:0] rdata_ff;
  // pin synchronisers
  logic [3:0] s1_ff, s2_ff, s3_ff;
  // controller engine
  shc_state_t st_ff;
  logic [3:0] div_ff, bits_ff, pbits_ff;
  logic sclk_ff, cs_ff, pico_ff, tail_ff, cont_ff;
  logic [7:0] txsh_ff;
  logic [QW-1:0] rxsh_ff, psh_ff, prx_ff;
  // peripheral engine
  logic pfirst_ff, poci_ff;

  // one serial checksum step over 8 or 16 data bits
  function automatic logic [QW-1:0] crc_step(input logic [QW-1:0] st, input logic [QW-1:0] d,
                                             input logic p16, input logic w16);
    logic [QW-1:0] c;
    logic fb;
    c = st;
    for (int i = QW - 1; i >= 0; i--) begin
      if (w16 || i < 8) begin
        if (p16) begin
          fb = c[15] ^ d[i];
          c = {c[14:0], 1'b0} ^ (fb ? POLY16 : 16'h0000);
        end else begin
          fb = c[7] ^ d[i];
          c = {8'h00, c[6:0], 1'b0} ^ (fb ? POLY8 : 16'h0000);
        end
      end
    end
    return c;
  endfunction

  // decoded configuration
  logic en, ctl_mode, p16, w16, ctl_act, p_act;
  logic [3:0] dss;
  logic [QW-1:0] seed, rxmask;
  assign en = ctrl_ff[CTL_EN];
  assign ctl_mode = ctrl_ff[CTL_CTRLR];
  assign p16 = ctrl_ff[CTL_POLY16];
  assign dss = ctrl_ff[CTL_DSS_HI:CTL_DSS_LO];
  assign w16 = (dss == DSS16);
  assign seed = p16 ? SEED16 : SEED8;
  assign rxmask = SEED16 >> (DSS16 - dss);
  assign ctl_act = en & ctl_mode;
  assign p_act = en & ~ctl_mode;

  // queue levels
  logic [QPW-1:0] tx_cnt, rx_cnt;
  logic tx_empty, tx_full, rx_empty, rx_full;
  logic [QW-1:0] tx_head, rx_head, p_word;
  assign tx_cnt = txw_ff - txr_ff;
  assign rx_cnt = rxw_ff - rxr_ff;
  assign tx_empty = (tx_cnt == '0);
  assign rx_empty = (rx_cnt == '0);
  assign tx_full = (tx_cnt == QPW'(QD));
  assign rx_full = (rx_cnt == QPW'(QD));
  assign tx_head = txq[txr_ff[QPW-2:0]];
  assign rx_head = rxq[rxr_ff[QPW-2:0]];
  assign p_word = tx_empty ? 16'h0000 : tx_head;

  // synchronised pin events
  logic cs_hi, cs_fall, s_rise, s_fall;
  assign cs_hi = s2_ff[SY_CS];
  assign cs_fall = s3_ff[SY_CS] & ~s2_ff[SY_CS];
  assign s_rise = ~s3_ff[SY_SCLK] & s2_ff[SY_SCLK];
  assign s_fall = s3_ff[SY_SCLK] & ~s2_ff[SY_SCLK];

  // controller timing events
  logic tick, c_rise, c_fall, start, resp_last, auto_due, auto_push, next_load, p_last;
  assign tick = (div_ff == 4'h0);
  assign c_rise = tick & ~sclk_ff;
  assign c_fall = tick & sclk_ff;
  assign start = ctl_act & (st_ff == ST_IDLE) & ~tx_empty;
  assign resp_last = ctl_act & (st_ff == ST_RESP) & c_rise & (bits_ff == dss);
  assign auto_due = ctrl_ff[CTL_AUTO] & ~p16 & ~crc_ins_ff & sent_ff & tx_empty;
  assign auto_push = resp_last & auto_due;
  assign next_load = ctl_act & (st_ff == ST_RESP) & c_fall & cont_ff;
  assign p_last = p_act & ~cs_hi & s_rise & (pbits_ff == dss);

  // bus handshake and decode
  logic req, fire, fire_wr, fire_rd, be_full, hdr_sel, hdr_ok, hdr_acc, hdr_busy, cs_idle;
  logic tx_wr, tx_q_ok, rxc_rd, txc_rd;
  logic [2:0] hdr_n;
  assign req = avs_read | avs_write;
  assign hdr_busy = (hdr_left_ff != 3'h0);
  assign fire = req & ack_ff & ce & ~auto_push;
  assign avs_waitrequest = req & ~fire;
  assign avs_readdata = rdata_ff;
  assign fire_wr = fire & avs_write;
  assign fire_rd = fire & avs_read;
  assign be_full = (avs_byteenable == 4'hf);
  assign hdr_sel = (avs_address == OFF_HDR1) | (avs_address == OFF_HDR2) |
                   (avs_address == OFF_HDR3) | (avs_address == OFF_HDR4);
  assign hdr_n = (avs_address == OFF_HDR1) ? 3'h1 : (avs_address == OFF_HDR2) ? 3'h2 :
                 (avs_address == OFF_HDR3) ? 3'h3 : 3'h4;
  assign cs_idle = ctl_mode | cs_hi;
  // open gate lets the first header through with select low
  assign hdr_ok = (cs_idle | (~gate_ff & ~hdr_pend_ff)) & (~gate_ff | hdr_en_ff);
  assign hdr_acc = fire_wr & be_full & hdr_sel & hdr_ok;
  assign tx_wr = fire_wr & be_full & (avs_address == OFF_TRANSMIT_DATA_PORT);
  // stand-alone checksum mode does not queue
  assign tx_q_ok = ~(ctrl_ff[CTL_GPCRC] & ~en) & ~tx_full;
  assign rxc_rd = fire_rd & (avs_address == OFF_RECEIVE_CHECKSUM_STATE);
  assign txc_rd = fire_rd & (avs_address == OFF_TRANSMIT_CHECKSUM_STATE);

  // queue traffic
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic [QW-1:0] tx_pdata, rx_pdata;
  assign tx_push = hdr_busy | auto_push | (tx_wr & tx_q_ok);
  assign tx_pdata = hdr_busy ? {8'h00, hdr_word_ff[31:24]} :
                    auto_push ? transmit_checksum_state_ff : avs_writedata[QW-1:0];
  assign tx_pop = start | next_load | (p_act & cs_fall & ~tx_empty) | (p_last & ~tx_empty);
  assign rx_push = ((st_ff == ST_TAIL) & ctl_act & tick & tail_ff) | next_load | p_last;
  assign rx_pdata = (p_last ? {prx_ff[14:0], s2_ff[SY_PICO]} : rxsh_ff) & rxmask;
  assign rx_pop = fire_rd & (avs_address == OFF_RECEIVE_DATA_PORT) & rxnz_ff;

  // bus acknowledge and read capture, one wait state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rxnz_ff <= 1'b0;
      rdata_ff <= '0;
    end else if (ce) begin
      ack_ff <= req & ~fire & ~hdr_busy;
      if (avs_read & ~ack_ff) begin
        rxnz_ff <= ~rx_empty;
        unique case (avs_address)
          OFF_CTRL: rdata_ff <= ctrl_ff;
          OFF_RECEIVE_DATA_PORT: rdata_ff <= {16'h0000, rx_empty ? 16'h0000 : rx_head};
          OFF_TRANSMIT_CHECKSUM_STATE: rdata_ff <= {16'h0000, transmit_checksum_state_ff};
          OFF_RECEIVE_CHECKSUM_STATE: rdata_ff <= {16'h0000, receive_checksum_state_ff};
          OFF_HDRC: rdata_ff <= {28'h0, gate_ff, hdr_ign_ff, hdr_cmt_ff, hdr_en_ff};
          OFF_STATUS: rdata_ff <= {22'h0, req_hold, (st_ff != ST_IDLE) | (p_act & ~cs_hi),
                                   rx_cnt, tx_cnt};
          default: rdata_ff <= '0;  // unmapped and write-only
        endcase
      end
    end
  end

  // control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
    end else if (ce && fire_wr && be_full && avs_address == OFF_CTRL) begin
      ctrl_ff <= avs_writedata;
    end
  end

  // header preload control and flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hdr_en_ff <= 1'b0;
      hdr_cmt_ff <= 1'b0;
      hdr_ign_ff <= 1'b0;
      gate_ff <= 1'b0;
      hdr_pend_ff <= 1'b0;
    end else if (ce) begin
      if (fire_wr && be_full && avs_address == OFF_HDRC) begin
        hdr_en_ff <= avs_writedata[HC_EN];
        gate_ff <= avs_writedata[HC_GATE];
      end
      // open gate: header write enables the feature itself
      if (hdr_acc && !gate_ff) begin
        hdr_en_ff <= 1'b1;
      end
      // commit on select fall, set beats software clear
      if (p_act && cs_fall && hdr_pend_ff) begin
        hdr_cmt_ff <= 1'b1;
        hdr_pend_ff <= 1'b0;
      end else begin
        if (fire_wr && be_full && avs_address == OFF_HDRC && avs_writedata[HC_CMT]) begin
          hdr_cmt_ff <= 1'b0;
        end
        if (hdr_acc) begin
          hdr_pend_ff <= 1'b1;
        end
      end
      // late header write
      if (fire_wr && hdr_sel && hdr_cmt_ff) begin
        hdr_ign_ff <= 1'b1;
      end else if (fire_wr && be_full && avs_address == OFF_HDRC && avs_writedata[HC_IGN]) begin
        hdr_ign_ff <= 1'b0;
      end
    end
  end

  // header byte pusher, one byte per clock, top byte first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hdr_left_ff <= 3'h0;
      hdr_word_ff <= '0;
    end else if (ce) begin
      if (hdr_acc) begin
        hdr_left_ff <= hdr_n;
        hdr_word_ff <= avs_writedata << (5'(3'h4 - hdr_n) * 5'h08);
      end else if (hdr_busy) begin
        hdr_left_ff <= hdr_left_ff - 3'h1;
        hdr_word_ff <= hdr_word_ff << 8;
      end
    end
  end

  // transmit queue
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txw_ff <= '0;
      txr_ff <= '0;
    end else if (ce) begin
      if (hdr_acc) begin
        txw_ff <= '0;
        txr_ff <= '0;
      end else begin
        if (tx_push) begin
          txq[txw_ff[QPW-2:0]] <= tx_pdata;
          txw_ff <= txw_ff + 1'b1;
        end
        if (tx_pop) begin
          txr_ff <= txr_ff + 1'b1;
        end
      end
    end
  end

  // receive queue, overflow drops the word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxw_ff <= '0;
      rxr_ff <= '0;
    end else if (ce) begin
      if (hdr_acc) begin
        rxw_ff <= '0;
        rxr_ff <= '0;
      end else begin
        if (rx_push && !rx_full) begin
          rxq[rxw_ff[QPW-2:0]] <= rx_pdata;
          rxw_ff <= rxw_ff + 1'b1;
        end
        if (rx_pop) begin
          rxr_ff <= rxr_ff + 1'b1;
        end
      end
    end
  end

  // checksum engines, always running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transmit_checksum_state_ff <= SEED8;
      receive_checksum_state_ff <= SEED8;
      crc_ins_ff <= 1'b0;
      sent_ff <= 1'b0;
    end else if (ce) begin
      if (fire_wr && be_full && avs_address == OFF_CTRL) begin
        transmit_checksum_state_ff <= avs_writedata[CTL_POLY16] ? SEED16 : SEED8;
        receive_checksum_state_ff <= avs_writedata[CTL_POLY16] ? SEED16 : SEED8;
      end else begin
        if (txc_rd || hdr_acc) begin
          transmit_checksum_state_ff <= seed;
          crc_ins_ff <= 1'b0;
          sent_ff <= 1'b0;
        end else begin
          if (tx_wr) begin
            transmit_checksum_state_ff <= crc_step(transmit_checksum_state_ff, avs_writedata[QW-1:0], p16, w16);
          end
          if (auto_push) begin
            crc_ins_ff <= 1'b1;
          end
          if (start || next_load) begin
            sent_ff <= 1'b1;
          end
        end
        // residue reaches zero once the received checksum is read too
        if (rxc_rd) begin
          receive_checksum_state_ff <= seed;
        end else if (rx_pop) begin
          receive_checksum_state_ff <= crc_step(receive_checksum_state_ff, rdata_ff[QW-1:0], p16, w16);
        end
      end
    end
  end

  // pin synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
      s3_ff <= SYNC_RST;
    end else if (ce) begin
      s1_ff <= {poci_i, pico_i, cs_n_i, sclk_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // controller control-word frame engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_IDLE;
      div_ff <= HALF_M1;
      bits_ff <= 4'h0;
      sclk_ff <= 1'b0;
      cs_ff <= 1'b1;
      pico_ff <= 1'b0;
      tail_ff <= 1'b0;
      cont_ff <= 1'b0;
      txsh_ff <= 8'h00;
      rxsh_ff <= '0;
    end else if (ce) begin
      if (!ctl_act) begin
        st_ff <= ST_IDLE;
        sclk_ff <= 1'b0;
        cs_ff <= 1'b1;
        pico_ff <= 1'b0;
        div_ff <= HALF_M1;
        cont_ff <= 1'b0;
      end else begin
        // half-period divider while a frame runs
        if (st_ff == ST_IDLE || tick) begin
          div_ff <= HALF_M1;
        end else begin
          div_ff <= div_ff - 4'h1;
        end
        unique case (st_ff)
          ST_IDLE: begin
            if (start) begin
              st_ff <= ST_CTRL;
              cs_ff <= 1'b0;
              txsh_ff <= tx_head[7:0];
              pico_ff <= tx_head[7];
              bits_ff <= 4'h0;
            end
          end
          ST_CTRL: begin
            if (tick) begin
              sclk_ff <= ~sclk_ff;
            end
            // shift control bits only, no sampling
            if (c_fall) begin
              if (bits_ff == CW_LAST) begin
                bits_ff <= 4'h0;
                pico_ff <= 1'b0;
                st_ff <= ST_WAIT;
              end else begin
                txsh_ff <= txsh_ff << 1;
                pico_ff <= txsh_ff[6];
                bits_ff <= bits_ff + 4'h1;
              end
            end
          end
          ST_WAIT: begin
            if (tick) begin
              sclk_ff <= ~sclk_ff;
            end
            if (c_fall) begin
              st_ff <= ST_RESP;
            end
          end
          ST_RESP: begin
            if (tick) begin
              sclk_ff <= ~sclk_ff;
            end
            if (c_rise) begin
              rxsh_ff <= {rxsh_ff[14:0], s2_ff[SY_POCI]};
              if (bits_ff == dss) begin
                bits_ff <= 4'h0;
                if (!tx_empty || auto_due) begin
                  cont_ff <= 1'b1;
                end else begin
                  st_ff <= ST_TAIL;
                  tail_ff <= 1'b0;
                end
              end else begin
                bits_ff <= bits_ff + 4'h1;
              end
            end
            if (next_load) begin
              cont_ff <= 1'b0;
              txsh_ff <= tx_head[7:0];
              pico_ff <= tx_head[7];
              st_ff <= ST_CTRL;
            end
          end
          ST_TAIL: begin
            if (tick) begin
              if (!tail_ff) begin
                sclk_ff <= 1'b0;
                tail_ff <= 1'b1;
              end else begin
                cs_ff <= 1'b1;
                st_ff <= ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // peripheral engine, sample rising, drive falling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psh_ff <= '0;
      prx_ff <= '0;
      pbits_ff <= 4'h0;
      pfirst_ff <= 1'b0;
      poci_ff <= 1'b0;
    end else if (ce) begin
      if (!p_act || cs_hi) begin
        poci_ff <= ctrl_ff[CTL_IDLE];
        pbits_ff <= 4'h0;
        pfirst_ff <= 1'b0;
      end else if (cs_fall) begin
        psh_ff <= p_word;
        poci_ff <= p_word[dss];
        pbits_ff <= 4'h0;
      end else if (s_rise) begin
        prx_ff <= {prx_ff[14:0], s2_ff[SY_PICO]};
        if (pbits_ff == dss) begin
          pbits_ff <= 4'h0;
          psh_ff <= p_word;
          pfirst_ff <= 1'b1;
        end else begin
          pbits_ff <= pbits_ff + 4'h1;
        end
      end else if (s_fall) begin
        if (pfirst_ff) begin
          poci_ff <= psh_ff[dss];
          pfirst_ff <= 1'b0;
        end else begin
          psh_ff <= psh_ff << 1;
          poci_ff <= psh_ff[dss - 4'h1];
        end
      end
    end
  end

  // pin drive
  assign sclk_o = sclk_ff;
  assign cs_n_o = cs_ff;
  assign pico_o = pico_ff;
  assign sclk_oe = ctl_act;
  assign cs_n_oe = ctl_act;
  assign pico_oe = ctl_act;
  assign poci_o = poci_ff;
  assign poci_oe = p_act;
  assign req_hold = hdr_pend_ff;

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);

  AST_CW_NO_CAPTURE: assert property ((st_ff == ST_CTRL) |=> $stable(rxsh_ff))
    else $error("response shifter moved during control word");
  AST_IDLE_PINS: assert property ((ctl_act && st_ff == ST_IDLE && !start) |=>
    (!sclk_o && cs_n_o && !pico_o))
    else $error("idle pins wrong");
  AST_START_MSB: assert property (start |=> (!cs_n_o && pico_o == $past(tx_head[7])))
    else $error("frame start without control MSB");
  AST_CS_LOW: assert property ((ctl_act && (st_ff == ST_WAIT || st_ff == ST_RESP)) |->
    !cs_n_o)
    else $error("select rose inside frame");
  AST_TAIL_TIME: assert property ((ctl_act && $rose(st_ff == ST_TAIL)) |->
    (!cs_n_o && ctl_act)[*8] ##1 cs_n_o)
    else $error("select release not one period after last bit");
  AST_RECEIVE_CHECKSUM_STATE_SEED: assert property ((rxc_rd && !(fire_wr)) |=> receive_checksum_state_ff == seed)
    else $error("receive checksum not reseeded");
  AST_HDR_PUSH4: assert property ((hdr_acc && hdr_n == 3'h4 && !ctl_mode) |->
    ##5 (tx_cnt == 4'h4 || !cs_hi))
    else $error("header bytes not pushed");
  AST_HDR_REFUSE: assert property ((fire_wr && hdr_sel && gate_ff && !cs_idle) |=>
    $stable(txw_ff))
    else $error("header accepted with select low");
  AST_CMT_STICKY: assert property ((hdr_cmt_ff && !(fire_wr && avs_address == OFF_HDRC)) |=>
    hdr_cmt_ff)
    else $error("committed flag dropped");
  AST_AUTO_INS: assert property ((auto_push && !hdr_acc) |=> tx_cnt == 4'h1)
    else $error("checksum not inserted on underflow");
endmodule
`default_nettype wire

/* shc_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module shc_far_model (
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic pico,
  output logic poci,
  // response to send, control byte seen
  input wire logic [7:0] resp,
  output logic [7:0] ctl_seen,
  output int n_rise
);
  logic [7:0] sh; // response shifter
  initial begin
    poci = 1'b0;
    n_rise = 0;
    ctl_seen = 8'h00;
  end
  // frame start: count from zero, load answer
  always @(negedge cs_n) begin
    n_rise <= 0;
    sh <= resp;
  end
  // released line toggles so stale data never looks valid
  always @(posedge cs_n) poci <= ~poci;
  // control bits latched on rising edges, 17 clocks per 8-bit answer frame
  always @(posedge sclk) if (!cs_n) begin
    if ((n_rise % 17) < 8) ctl_seen <= {ctl_seen[6:0], pico};
    n_rise <= n_rise + 1;
  end
  // one wait clock, then answer bits on falling edges; answer repeats per frame
  always @(negedge sclk) if (!cs_n && (n_rise % 17) >= 9) begin
    poci <= sh[7];
    sh <= {sh[6:0], sh[7]};
  end else begin
    poci <= ~poci;
  end
endmodule
`default_nettype wire

/* shc_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module shc_top_tb_top;
  import shc_pkg::*;
  logic clk, rst, ce, rd, wr, wait_r, hold;
  logic sck, sck_e, cs, cs_e, pc, pc_e, po, po_e, far_po, cs_far;
  logic [AW-1:0] adr;
  logic [DW-1:0] wd, rdat, q;
  logic [3:0] be;
  logic [7:0] resp, ctl_seen, crc, b;
  int n_rise, n, bad_count, n_compared;
  logic [7:0] exp_q[$]; // expected received words
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  shc_top i_dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_r), .sclk_i(sck_e ? sck : 1'b0), .sclk_o(sck), .sclk_oe(sck_e),
    .cs_n_i(cs_e ? cs : cs_far), .cs_n_o(cs), .cs_n_oe(cs_e), .pico_i(pc_e ? pc : 1'b0),
    .pico_o(pc), .pico_oe(pc_e), .poci_i(po_e ? po : far_po), .poci_o(po), .poci_oe(po_e),
    .req_hold(hold));
  shc_far_model i_far (.sclk(sck_e ? sck : 1'b0), .cs_n(cs_e ? cs : 1'b1),
    .pico(pc_e ? pc : 1'b0), .poci(far_po), .resp(resp), .ctl_seen(ctl_seen), .n_rise(n_rise));
  // reference checksum, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one bus access, held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
      if (k > 50) begin
        bad_count++;
        wrap_up();
      end
    end while (wait_r);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // wait until select has fallen and risen again, bounded
  task wait_frame(input int lim);
    n = 0;
    while (cs !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    while (cs !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      wrap_up();
    end
  endtask
  initial begin
    rst = 1'b1; ce = 1'b1; rd = 1'b0; wr = 1'b0; adr = '0; wd = '0; be = 4'hf;
    bad_count = 0; n_compared = 0; resp = 8'h00; cs_far = 1'b1;
    void'($urandom(32'h0fd0));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // idle levels and reset values
    chk("cs idle", 32'(cs), 32'h1);
    chk("sclk idle", 32'(sck), 32'h0);
    chk("pico idle", 32'(pc), 32'h0);
    bus(1'b0, OFF_CTRL, '0);
    chk("ctrl reset", q, CTRL_RST);
    bus(1'b0, OFF_TRANSMIT_CHECKSUM_STATE, '0);
    chk("tx seed", q & 32'hffff, 32'h00ff);
    bus(1'b0, 6'h3c, '0);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    // stand-alone checksum with port off
    bus(1'b1, OFF_CTRL, 32'h0000_0008);
    crc = 8'hff;
    repeat (4) begin
      b = 8'($urandom());
      bus(1'b1, OFF_TRANSMIT_DATA_PORT, 32'(b));
      crc = crc8(crc, b);
    end
    bus(1'b0, OFF_TRANSMIT_CHECKSUM_STATE, '0);
    chk("tx crc", q & 32'hffff, 32'(crc));
    bus(1'b0, OFF_TRANSMIT_CHECKSUM_STATE, '0);
    chk("tx reseed", q & 32'hffff, 32'h00ff);
    $display("test checksum done");
    // controller frames, second answer is the checksum of the first
    bus(1'b1, OFF_CTRL, 32'h0000_0703);
    for (int f = 0; f < 2; f++) begin
      resp = (f == 0) ? 8'($urandom()) : crc8(8'hff, exp_q[0]);
      b = 8'($urandom());
      exp_q.push_back(resp);
      bus(1'b1, OFF_TRANSMIT_DATA_PORT, 32'(b));
      wait_frame(400);
      chk("control byte", 32'(ctl_seen), 32'(b));
      chk("frame clocks", 32'(n_rise), 32'd17);
    end
    repeat (2) begin
      bus(1'b0, OFF_RECEIVE_DATA_PORT, '0);
      chk("rx word", q & 32'hffff, 32'(exp_q.pop_front()));
    end
    bus(1'b0, OFF_RECEIVE_CHECKSUM_STATE, '0);
    chk("rx residue", q & 32'hffff, 32'h0);
    $display("test frames done");
    // back-to-back frames, checksum appended on underflow
    bus(1'b1, OFF_CTRL, 32'h0000_4703);
    resp = 8'($urandom());
    b = 8'($urandom());
    crc = crc8(8'hff, b);
    bus(1'b1, OFF_TRANSMIT_DATA_PORT, 32'(b));
    b = 8'($urandom());
    crc = crc8(crc, b);
    bus(1'b1, OFF_TRANSMIT_DATA_PORT, 32'(b));
    wait_frame(600);
    chk("auto checksum", 32'(ctl_seen), 32'(crc));
    chk("continuous clocks", 32'(n_rise), 32'd51);
    bus(1'b0, OFF_STATUS, '0);
    chk("levels", q & 32'h3ff, 32'h030);
    $display("test auto checksum done");
    // peripheral header preload, commit on select fall
    bus(1'b1, OFF_CTRL, 32'h0002_0701);
    bus(1'b1, OFF_HDR4, 32'h3c5a_a5c3);
    chk("idle out", 32'({po_e, po}), 32'h3);
    bus(1'b0, OFF_STATUS, '0);
    chk("header level", q & 32'h3ff, 32'h204);
    chk("hold set", 32'(hold), 32'h1);
    bus(1'b0, OFF_HDRC, '0);
    chk("enable auto", q, 32'h1);
    cs_far <= 1'b0;
    repeat (5) @(posedge clk);
    chk("header msb", 32'(po), 32'h0);
    chk("hold released", 32'(hold), 32'h0);
    bus(1'b1, OFF_HDR1, 32'h0000_0011);
    bus(1'b0, OFF_HDRC, '0);
    chk("flags", q, 32'h7);
    cs_far <= 1'b1;
    $display("test header done");
    wrap_up();
  end
endmodule
`default_nettype wire
